// ===== design/hac_channel.sv
`timescale 1ns/1ps
// Summary of operation
// - Second address byte compared with seven bits
// - All-call address overrides both address patterns
// - Second pattern used only when enabled
// - Failed address packets never reach receive fifo
// - Transmit entry is byte plus two tags
// - Fifo status settles after data moves
// - Fifo port reads receive, writes transmit
// - Filter bit accepts matching or all-call only
// - Receiver stops after packet, starts immediately
// - Transmitter stops after packet, starts at next transmit slot
// - End tag appends check sequence, self-clears
// - Abort tag aborts packet, self-clears
// - Empty fifo between packets sends mark idle or flags
// - Transparent mode: raw bytes, no framing
// - Enable falling edge aligns transparent mode
// - Free-run keeps both sides clocked while both are enabled
// - First address byte compared six/seven bits
// - Status shows tag of next receive byte
module hac_channel
  import hac_pkg::*;
#(
  parameter int FIFO_DEPTH = HAC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Microprocessor register port
  input wire logic bus_sel,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [4:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // Timeslot bit streams to and from the peer
  input wire logic tx_bit_en,
  output logic tx_bit,
  input wire logic rx_bit_en,
  input wire logic rx_bit,
  // Internal clock gating
  output logic tx_clock_on,
  output logic rx_clock_on
);
  typedef enum logic [2:0] {
    TX_OFF, TX_FILL, TX_FLAG, TX_DATA, TX_FCS, TX_CLOSE, TX_ABORT
  } hac_tx_state_type;

  typedef enum logic [1:0] {
    RX_OFF, RX_HUNT, RX_FRAME
  } hac_rx_state_type;

  typedef struct packed {
    logic [7:0] addr1;
    logic [7:0] addr2;
    logic [7:0] ctl1;
    logic seven;
    logic [7:0] rdata;
    logic prev_transmitter_en;
    logic prev_receiver_en;
    hac_tx_state_type tx_st;
    logic [7:0] tx_sh;
    logic [2:0] tx_bit;
    logic [2:0] tx_ones;
    logic [15:0] tx_crc;
    logic tx_eop;
    logic tx_abt;
    logic tx_cnt;
    logic tx_line;
    hac_rx_state_type rx_st;
    logic [7:0] rx_raw;
    logic [7:0] rx_sh;
    logic [2:0] rx_bit;
    logic [2:0] rx_ones;
    logic [15:0] rx_crc;
    logic [2:0][7:0] rx_hold;
    logic [1:0] rx_n;
    logic rx_first;
    logic rx_drop;
  } hac_chan_type;

  hac_chan_type s_q, s_d;

  // Fifo hookup
  logic tx_push, tx_avail, tx_pop, tx_seen_empty, tx_seen_full;
  logic [HAC_ENTRY_W-1:0] tx_push_data, tx_head;
  logic rx_push, rx_avail, rx_pop, rx_seen_empty, rx_seen_full;
  logic [HAC_ENTRY_W-1:0] rx_push_data, rx_head;
  logic addr_ok;
  logic [1:0] tx_stat, rx_stat;
  logic free_run;

  // Entry is the byte with the two tag bits above it
  assign tx_push_data = {s_q.ctl1[HAC_C1_ABT], s_q.ctl1[HAC_C1_EOP], bus_wdata};

  hac_fifo #(
    .WIDTH(HAC_ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(tx_push),
    .in_ready(),
    .in_data(tx_push_data),
    .out_valid(tx_avail),
    .out_ready(tx_pop),
    .out_data(tx_head),
    .seen_empty(tx_seen_empty),
    .seen_full(tx_seen_full)
  );

  hac_fifo #(
    .WIDTH(HAC_ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(rx_push),
    .in_ready(),
    .in_data(rx_push_data),
    .out_valid(rx_avail),
    .out_ready(rx_pop),
    .out_data(rx_head),
    .seen_empty(rx_seen_empty),
    .seen_full(rx_seen_full)
  );

  // Oldest held byte is the first address byte
  hac_addr_match u_addr (
    .first_byte(s_q.rx_hold[2]),
    .second_byte(s_q.rx_hold[1]),
    .first_address_pattern(s_q.addr1),
    .second_address_pattern(s_q.addr2),
    .seven_bit(s_q.seven),
    .match(addr_ok)
  );

  // Status codes come from the settled fifo flags
  assign tx_stat = tx_seen_empty ? HAC_TXS_EMPTY : tx_seen_full ? HAC_TXS_FULL : HAC_TXS_PART;
  assign rx_stat = rx_seen_empty ? HAC_RXS_EMPTY : rx_seen_full ? HAC_RXS_FULL : HAC_RXS_PART;

  // Free-run needs both enables as well
  assign free_run = s_q.ctl1[HAC_C1_CONTINUOUS_RUN] && s_q.ctl1[HAC_C1_RECEIVER_EN] && s_q.ctl1[HAC_C1_TRANSMITTER_EN];

  // Outputs
  assign bus_rdata = s_q.rdata;
  assign tx_bit = s_q.tx_line;
  assign tx_clock_on = free_run || s_q.tx_st != TX_OFF;
  assign rx_clock_on = free_run || s_q.rx_st != RX_OFF;

  always_comb begin
    logic tr, tx_run, rx_run, filter, byte_end, want_fill, take, b, kill;
    logic [7:0] raw_n, sh_n;
    tr = s_q.ctl1[HAC_C1_TRANSP];
    tx_run = s_q.ctl1[HAC_C1_TRANSMITTER_EN];
    rx_run = s_q.ctl1[HAC_C1_RECEIVER_EN];
    filter = s_q.ctl1[HAC_C1_FILTER];
    byte_end = 1'b0;
    want_fill = 1'b0;
    take = 1'b0;
    b = 1'b0;
    kill = 1'b0;
    raw_n = '0;
    sh_n = '0;
    s_d = s_q;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_push_data = '0;
    s_d.prev_transmitter_en = tx_run;
    s_d.prev_receiver_en = rx_run;

    // Register writes; unmapped offsets are ignored
    if (bus_sel && bus_wr) begin
      unique case (bus_addr)
        HAC_OFS_ADDR1: s_d.addr1 = bus_wdata;
        HAC_OFS_ADDR2: s_d.addr2 = bus_wdata;
        HAC_OFS_CTL1: s_d.ctl1 = bus_wdata;
        HAC_OFS_CTL2: s_d.seven = bus_wdata[HAC_C2_SEVEN];
        HAC_OFS_FIFO: begin
          tx_push = 1'b1;
          s_d.ctl1[HAC_C1_EOP] = 1'b0;
          s_d.ctl1[HAC_C1_ABT] = 1'b0;
        end
        default: ;
      endcase
    end

    // Register reads land one cycle later; unmapped read as zero
    if (bus_sel && bus_rd) begin
      unique case (bus_addr)
        HAC_OFS_ADDR1: s_d.rdata = s_q.addr1;
        HAC_OFS_ADDR2: s_d.rdata = s_q.addr2;
        HAC_OFS_CTL1: s_d.rdata = s_q.ctl1;
        HAC_OFS_CTL2: s_d.rdata = {3'h0, s_q.seven, 4'h0};
        HAC_OFS_STATUS: s_d.rdata = {2'h0, rx_head[9:8], tx_stat, rx_stat};
        HAC_OFS_FIFO: begin
          s_d.rdata = rx_head[7:0];
          rx_pop = 1'b1;
        end
        default: s_d.rdata = '0;
      endcase
    end

    // Transmitter; transparent restart realigns to the slot
    if (tr && s_q.prev_transmitter_en && !tx_run) begin
      s_d.tx_st = TX_OFF;
      s_d.tx_bit = '0;
      s_d.tx_ones = '0;
    end else if (tx_bit_en) begin
      if (s_q.tx_st == TX_OFF) begin
        s_d.tx_line = HAC_RST_LINE;
        want_fill = tx_run;
      end else if (s_q.tx_ones == HAC_STUFF_RUN) begin
        // Five ones sent, slip in a zero
        s_d.tx_line = 1'b0;
        s_d.tx_ones = '0;
      end else begin
        b = s_q.tx_sh[0];
        s_d.tx_line = b;
        s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
        s_d.tx_bit = s_q.tx_bit + 3'h1;
        // Flags and aborts never count toward stuffing
        if (!tr && b && (s_q.tx_st == TX_DATA || s_q.tx_st == TX_FCS)) begin
          s_d.tx_ones = s_q.tx_ones + 3'h1;
        end else begin
          s_d.tx_ones = '0;
        end
        byte_end = s_q.tx_bit == HAC_LAST_BIT;
      end
    end

    // Choose the next byte at each byte boundary
    if (byte_end) begin
      unique case (s_q.tx_st)
        TX_DATA: begin
          if (s_q.tx_abt && !tr) begin
            s_d.tx_sh = HAC_ABORT;
            s_d.tx_st = TX_ABORT;
          end else if (s_q.tx_eop && !tr) begin
            s_d.tx_sh = ~s_q.tx_crc[7:0];
            s_d.tx_cnt = 1'b0;
            s_d.tx_st = TX_FCS;
          end else if (tx_avail) begin
            take = 1'b1;
          end else if (tr) begin
            want_fill = 1'b1;
          end else begin
            // Underrun mid-packet closes it with an abort
            s_d.tx_sh = HAC_ABORT;
            s_d.tx_st = TX_ABORT;
          end
        end
        TX_FCS: begin
          if (!s_q.tx_cnt) begin
            s_d.tx_sh = ~s_q.tx_crc[15:8];
            s_d.tx_cnt = 1'b1;
          end else begin
            s_d.tx_sh = HAC_FLAG;
            s_d.tx_st = TX_CLOSE;
          end
        end
        TX_FLAG: begin
          take = tx_avail;
          want_fill = !tx_avail;
        end
        TX_FILL, TX_CLOSE, TX_ABORT, TX_OFF: begin
          if (!tx_run) begin
            s_d.tx_st = TX_OFF; // stops only between packets
          end else if (tx_avail && (tr || s_q.tx_st == TX_CLOSE ||
                       (s_q.tx_st == TX_FILL && s_q.ctl1[HAC_C1_FILL]))) begin
            take = 1'b1;
          end else if (tx_avail) begin
            // Leaving mark idle needs an opening flag first
            s_d.tx_sh = HAC_FLAG;
            s_d.tx_st = TX_FLAG;
          end else begin
            want_fill = 1'b1;
          end
        end
      endcase
    end

    // Fill while the fifo is empty between packets, and on the first slot after TX_OFF
    if (want_fill) begin
      s_d.tx_st = TX_FILL;
      s_d.tx_sh = s_q.ctl1[HAC_C1_FILL] ? HAC_FLAG : HAC_MARK;
      s_d.tx_bit = '0;
    end
    if (take) begin
      tx_pop = 1'b1;
      s_d.tx_st = TX_DATA;
      s_d.tx_sh = tx_head[7:0];
      s_d.tx_eop = tx_head[8];
      s_d.tx_abt = tx_head[9];
      s_d.tx_crc = hac_crc_byte(s_q.tx_st == TX_DATA ? s_q.tx_crc : HAC_CRC_INIT,
                                tx_head[7:0]);
    end

    // Receiver enable, transparent restart realign
    if (tr && s_q.prev_receiver_en && !rx_run) begin
      s_d.rx_st = RX_OFF;
      s_d.rx_bit = '0;
    end else if (s_q.rx_st == RX_OFF) begin
      // Enabling takes effect at once
      if (rx_run) begin
        s_d.rx_st = tr ? RX_FRAME : RX_HUNT;
      end
      s_d.rx_bit = '0;
      s_d.rx_ones = '0;
      s_d.rx_raw = '0;
    end else if (!rx_run && (tr || s_q.rx_st == RX_HUNT)) begin
      s_d.rx_st = RX_OFF;
    end else if (rx_bit_en && tr) begin
      // Raw bytes, no flags, stuffing or
      sh_n = {rx_bit, s_q.rx_sh[7:1]};
      s_d.rx_sh = sh_n;
      s_d.rx_bit = s_q.rx_bit + 3'h1;
      if (s_q.rx_bit == HAC_LAST_BIT) begin
        rx_push = 1'b1;
        rx_push_data = {HAC_TAG_BODY, sh_n};
      end
    end else if (rx_bit_en) begin
      raw_n = {rx_bit, s_q.rx_raw[7:1]};
      s_d.rx_raw = raw_n;
      if (!rx_bit) begin
        s_d.rx_ones = '0;
      end else if (s_q.rx_ones != HAC_RUN_MAX) begin
        s_d.rx_ones = s_q.rx_ones + 3'h1;
      end
      if (rx_bit && s_q.rx_ones >= HAC_ABORT_RUN) begin
        // Seven ones: abort or idle, packet dropped
        s_d.rx_st = rx_run ? RX_HUNT : RX_OFF;
      end else if (raw_n == HAC_FLAG) begin
        // Closing flag releases the last byte with its verdict
        if (s_q.rx_st == RX_FRAME && s_q.rx_n == HAC_HOLD_FULL &&
            s_q.rx_bit == HAC_LAST_BIT && !s_q.rx_drop && !s_q.rx_first) begin
          rx_push = 1'b1;
          rx_push_data = {s_q.rx_crc == HAC_CRC_GOOD ? HAC_TAG_GOOD : HAC_TAG_BAD,
                          s_q.rx_hold[2]};
        end
        s_d.rx_st = rx_run ? RX_FRAME : RX_OFF;
        s_d.rx_bit = '0;
        s_d.rx_n = '0;
        s_d.rx_crc = HAC_CRC_INIT;
        s_d.rx_first = 1'b1;
        s_d.rx_drop = 1'b0;
      end else if (s_q.rx_ones == HAC_STUFF_RUN && !rx_bit) begin
        s_d.rx_ones = '0; // stuffed zero removed
      end else if (s_q.rx_st == RX_FRAME) begin
        sh_n = {rx_bit, s_q.rx_sh[7:1]};
        s_d.rx_sh = sh_n;
        s_d.rx_bit = s_q.rx_bit + 3'h1;
        if (s_q.rx_bit == HAC_LAST_BIT) begin
          // Three bytes held so the check sequence never lands in the fifo
          s_d.rx_crc = hac_crc_byte(s_q.rx_crc, sh_n);
          s_d.rx_hold = {s_q.rx_hold[1:0], sh_n};
          if (s_q.rx_n != HAC_HOLD_FULL) begin
            s_d.rx_n = s_q.rx_n + 2'h1;
          end else begin
            kill = s_q.rx_first ? filter && !addr_ok : s_q.rx_drop;
            s_d.rx_drop = kill;
            s_d.rx_first = 1'b0;
            rx_push = !kill;
            rx_push_data = {s_q.rx_first ? HAC_TAG_FIRST : HAC_TAG_BODY, s_q.rx_hold[2]};
          end
        end
      end
    end
  end

  // All channel state in one register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.tx_line <= HAC_RST_LINE;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ===== design/hac_pkg.sv
package hac_pkg;
  // Register offsets on the microprocessor port
  localparam logic [4:0] HAC_OFS_ADDR1 = 5'h10;
  localparam logic [4:0] HAC_OFS_ADDR2 = 5'h11;
  localparam logic [4:0] HAC_OFS_FIFO = 5'h12;
  localparam logic [4:0] HAC_OFS_CTL1 = 5'h13;
  localparam logic [4:0] HAC_OFS_STATUS = 5'h14;
  localparam logic [4:0] HAC_OFS_CTL2 = 5'h15;
  // Control register one bits
  localparam int HAC_C1_FILTER = 7;
  localparam int HAC_C1_RECEIVER_EN = 6;
  localparam int HAC_C1_TRANSMITTER_EN = 5;
  localparam int HAC_C1_EOP = 4;
  localparam int HAC_C1_ABT = 3;
  localparam int HAC_C1_FILL = 2;
  localparam int HAC_C1_TRANSP = 1;
  localparam int HAC_C1_CONTINUOUS_RUN = 0;
  // Address register and control two bits
  localparam int HAC_AR_EN = 0;
  localparam int HAC_C2_SEVEN = 4;
  // Reset values
  localparam logic [7:0] HAC_RST_REG = 8'h00;
  localparam logic HAC_RST_LINE = 1'b1;
  // Receive byte tags
  localparam logic [1:0] HAC_TAG_BODY = 2'h0;
  localparam logic [1:0] HAC_TAG_FIRST = 2'h1;
  localparam logic [1:0] HAC_TAG_GOOD = 2'h2;
  localparam logic [1:0] HAC_TAG_BAD = 2'h3;
  // Fifo status codes
  localparam logic [1:0] HAC_TXS_FULL = 2'h0;
  localparam logic [1:0] HAC_TXS_EMPTY = 2'h2;
  localparam logic [1:0] HAC_TXS_PART = 2'h3;
  localparam logic [1:0] HAC_RXS_EMPTY = 2'h0;
  localparam logic [1:0] HAC_RXS_PART = 2'h1;
  localparam logic [1:0] HAC_RXS_FULL = 2'h3;
  // Line patterns, sent least significant bit first
  localparam logic [7:0] HAC_FLAG = 8'h7e;
  localparam logic [7:0] HAC_MARK = 8'hff;
  localparam logic [7:0] HAC_ABORT = 8'h7f;
  localparam logic [2:0] HAC_STUFF_RUN = 3'h5;
  localparam logic [2:0] HAC_ABORT_RUN = 3'h6;
  localparam logic [2:0] HAC_RUN_MAX = 3'h7;
  localparam logic [2:0] HAC_LAST_BIT = 3'h7;
  localparam logic [6:0] HAC_ALL_CALL = 7'h7f;
  // Frame check sequence
  localparam logic [15:0] HAC_CRC_INIT = 16'hffff;
  localparam logic [15:0] HAC_CRC_POLY = 16'h8408;
  localparam logic [15:0] HAC_CRC_GOOD = 16'hf0b8;
  // Fifo geometry
  localparam int HAC_ENTRY_W = 10;
  localparam int HAC_FIFO_DEPTH = 16;
  localparam logic [1:0] HAC_HOLD_FULL = 2'h3;

  // Reflected CRC-16 over one byte
  function automatic logic [15:0] hac_crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ HAC_CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction
endpackage

// ===== design/hac_fifo.sv
`timescale 1ns/1ps
module hac_fifo
  import hac_pkg::*;
#(
  parameter int WIDTH = HAC_ENTRY_W,
  parameter int DEPTH = HAC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Settled status for software
  output logic seen_empty,
  output logic seen_full
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic empty;
    logic full;
  } hac_fifo_state_type;

  hac_fifo_state_type s_q, s_d;
  logic push, pop;

  // Handshakes follow the live count
  assign in_ready = s_q.cnt != FULL_CNT;
  assign out_valid = s_q.cnt != '0;
  assign out_data = s_q.mem[s_q.rd];
  assign seen_empty = s_q.empty;
  assign seen_full = s_q.full;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Depth must be a power of two so the pointers wrap
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    // Status trails the move by one cycle
    s_d.empty = s_q.cnt == '0;
    s_d.full = s_q.cnt == FULL_CNT;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.empty <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ===== design/hac_addr_match.sv
`timescale 1ns/1ps
module hac_addr_match
  import hac_pkg::*;
(
  // Received address bytes
  input wire logic [7:0] first_byte,
  input wire logic [7:0] second_byte,
  // Programmed patterns
  input wire logic [7:0] first_address_pattern,
  input wire logic [7:0] second_address_pattern,
  input wire logic seven_bit,
  // Verdict
  output logic match
);
  logic a1en, second_address_compare_en, m1, m2, all1, all2;

  // Enables sit in bit 0 of each pattern register
  assign a1en = first_address_pattern[HAC_AR_EN];
  assign second_address_compare_en = second_address_pattern[HAC_AR_EN];
  // Six bits, or seven when selected
  assign m1 = seven_bit ? first_byte[7:1] == first_address_pattern[7:1]
                        : first_byte[7:2] == first_address_pattern[7:2];
  // Seven-bit second pattern, bit 7 most significant
  assign m2 = second_byte[7:1] == second_address_pattern[7:1];
  // All-call only honoured while its enable is high
  assign all1 = a1en && (seven_bit ? first_byte[7:1] == HAC_ALL_CALL
                                   : first_byte[7:2] == HAC_ALL_CALL[5:0]);
  assign all2 = second_address_compare_en && second_byte[7:1] == HAC_ALL_CALL;
  // All-call overrides both patterns; a cleared enable drops its pattern
  assign match = all1 || all2 || ((!a1en || m1) && (!second_address_compare_en || m2));
endmodule

// ===== testbench/hac_channel_sva.sv
`timescale 1ns/1ps
module hac_channel_sva
  import hac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic bus_sel,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [4:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  // Timeslot stream
  input wire logic tx_bit_en,
  input wire logic tx_bit,
  input wire logic rx_bit_en,
  input wire logic rx_bit,
  // Clock gating
  input wire logic tx_clock_on,
  input wire logic rx_clock_on
);
  logic ctl_wr;
  logic ctl_rd;
  logic fifo_wr;
  logic any_rd;
  logic gap_rd;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Decoded accesses, shared by several checks
  assign ctl_wr = bus_sel && bus_wr && (bus_addr == HAC_OFS_CTL1);
  assign ctl_rd = bus_sel && bus_rd && (bus_addr == HAC_OFS_CTL1);
  assign fifo_wr = bus_sel && bus_wr && (bus_addr == HAC_OFS_FIFO);
  assign any_rd = bus_sel && bus_rd;
  assign gap_rd = any_rd && (bus_addr < HAC_OFS_ADDR1 || bus_addr > HAC_OFS_CTL2);

  a_rdata_hold: assert property (!$past(any_rd) |-> $stable(bus_rdata))
    else $error("read data moved without a read");
  a_gap_zero: assert property (gap_rd |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctl_readback: assert property (ctl_wr ##1 ctl_rd |=> bus_rdata == $past(bus_wdata, 2))
    else $error("control readback differs");
  a_tag_clear: assert property (fifo_wr ##1 ctl_rd |=> bus_rdata[4:3] == 2'b00)
    else $error("tags not cleared by fifo write");
  a_tx_start: assert property (ctl_wr && bus_wdata[HAC_C1_TRANSMITTER_EN] |=> ##[0:2] tx_clock_on)
    else $error("transmitter did not start");
  a_rx_start: assert property (ctl_wr && bus_wdata[HAC_C1_RECEIVER_EN] |=> ##[0:2] rx_clock_on)
    else $error("receiver did not start");
  // Stop waits for a byte boundary, so the bound is generous
  a_tx_stop: assert property (ctl_wr && !bus_wdata[HAC_C1_TRANSMITTER_EN] |=> ##[0:1000] (!tx_clock_on || ctl_wr))
    else $error("transmitter never stopped");
  a_bit_pace: assert property ($changed(tx_bit) |-> $past(tx_bit_en))
    else $error("line bit changed off its slot");
  a_tx_off_mark: assert property (!tx_clock_on && !$past(tx_clock_on) && $past(tx_bit_en) |-> tx_bit)
    else $error("stopped transmitter sent a zero");
endmodule

bind hac_channel hac_channel_sva u_sva (
  .clk(clk), .rst_n(rst_n), .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .tx_bit_en(tx_bit_en), .tx_bit(tx_bit), .rx_bit_en(rx_bit_en), .rx_bit(rx_bit),
  .tx_clock_on(tx_clock_on), .rx_clock_on(rx_clock_on)
);

// ===== testbench/hac_peer_model.sv
`timescale 1ns/1ps
module hac_peer_model
  import hac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Transmit slot
  output logic tx_bit_en,
  input wire logic tx_bit,
  // Receive slot
  output logic rx_bit_en,
  output logic rx_bit,
  // Zeros seen on the transmit line
  output logic [7:0] zero_cnt
);
  int ones;

  // Slot every other cycle, launched off the sampling edge
  initial begin
    tx_bit_en = 1'b0;
    rx_bit_en = 1'b0;
    rx_bit = 1'b1;
    forever begin
      @(negedge clk);
      tx_bit_en = ~tx_bit_en & rst_n;
    end
  end

  // Zero tally; a window over it gives framing content
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_cnt <= 8'h00;
    end else if (tx_bit_en && !tx_bit) begin
      zero_cnt <= zero_cnt + 8'h01;
    end
  end

  // One bit, then the line no longer shows it
  task automatic put_bit(input logic b);
    @(negedge clk);
    rx_bit = b;
    rx_bit_en = 1'b1;
    @(negedge clk);
    rx_bit_en = 1'b0;
    rx_bit = ~b;
  endtask

  // Flags, five stuffed bytes sent low bit first, closing flag
  task automatic send_frame(input logic [39:0] body);
    for (int k = 0; k < 24; k++) put_bit(HAC_FLAG[k % 8]);
    ones = 0;
    for (int k = 0; k < 40; k++) begin
      put_bit(body[k]);
      ones = body[k] ? ones + 1 : 0;
      if (ones == 5) begin
        put_bit(1'b0);
        ones = 0;
      end
    end
    for (int k = 0; k < 8; k++) put_bit(HAC_FLAG[k]);
  endtask
endmodule

// ===== testbench/hac_channel_bench.sv
`timescale 1ns/1ps
module hac_channel_bench
  import hac_pkg::*;
;
  logic clk;
  logic rst_n;
  logic bus_sel;
  logic bus_wr;
  logic bus_rd;
  logic [4:0] bus_addr;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic tx_bit_en;
  logic tx_bit;
  logic rx_bit_en;
  logic rx_bit;
  logic tx_clock_on;
  logic rx_clock_on;
  logic [7:0] zero_cnt;
  logic [7:0] z0;
  int error_cnt = 0;
  int n_tests = 0;
  // Second byte sent, second and first patterns; first and last cases dropped
  logic [7:0] a2_tab [5] = '{8'h22, 8'h44, 8'hff, 8'h22, 8'h44};
  logic [7:0] r2_tab [5] = '{8'h45, 8'h45, 8'h45, 8'h44, 8'h45};
  logic [7:0] r1_tab [5] = '{8'h00, 8'h00, 8'h11, 8'h0d, 8'h11};

  hac_channel #(.FIFO_DEPTH(4)) dut (
    .clk(clk), .rst_n(rst_n), .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .tx_bit_en(tx_bit_en), .tx_bit(tx_bit), .rx_bit_en(rx_bit_en), .rx_bit(rx_bit),
    .tx_clock_on(tx_clock_on), .rx_clock_on(rx_clock_on)
  );
  hac_peer_model peer (
    .clk(clk), .rst_n(rst_n), .tx_bit_en(tx_bit_en), .tx_bit(tx_bit),
    .rx_bit_en(rx_bit_en), .rx_bit(rx_bit), .zero_cnt(zero_cnt)
  );

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One access per cycle; the strobes stay up for back-to-back use
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    bus_sel = 1'b1;
    bus_wr = w;
    bus_rd = ~w;
    bus_addr = a;
    bus_wdata = d;
    @(negedge clk);
  endtask

  task automatic idle(input int n);
    bus_sel = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (n) @(negedge clk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    acc(1'b0, a, 8'h00);
    check(bus_rdata & m, e);
  endtask

  // Zeros over 64 transmit slots
  task automatic zeros(input logic [7:0] e);
    z0 = zero_cnt;
    idle(128);
    check(zero_cnt - z0, e);
  endtask

  // Hang guard, far beyond the few thousand cycles expected
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    bus_addr = 5'h00;
    bus_wdata = 8'h00;
    idle(4);
    rst_n = 1'b1;
    rd(HAC_OFS_CTL1, 8'h00);
    rd(HAC_OFS_ADDR2, 8'h00);
    rd(5'h1f, 8'h00);
    rd(HAC_OFS_STATUS, 8'h08, 8'h3f);
    // Tags ride with the byte; status lags the push
    acc(1'b1, HAC_OFS_CTL1, 8'h18);
    rd(HAC_OFS_CTL1, 8'h18);
    acc(1'b1, HAC_OFS_FIFO, 8'ha5);
    rd(HAC_OFS_STATUS, 8'h08, 8'h0c);
    rd(HAC_OFS_CTL1, 8'h00);
    acc(1'b1, HAC_OFS_CTL1, 8'h10);
    acc(1'b1, HAC_OFS_FIFO, 8'hff);
    rd(HAC_OFS_CTL1, 8'h00);
    idle(2);
    rd(HAC_OFS_STATUS, 8'h0c, 8'h0c);
    // Queue drains once enabled, then flags or marks fill
    acc(1'b1, HAC_OFS_CTL1, 8'h24);
    idle(400);
    rd(HAC_OFS_STATUS, 8'h08, 8'h0c);
    zeros(8'h10);
    acc(1'b1, HAC_OFS_CTL1, 8'h20);
    idle(40);
    zeros(8'h00);
    acc(1'b1, HAC_OFS_CTL1, 8'h00);
    idle(40);
    check({7'h00, tx_clock_on}, 8'h00);
    zeros(8'h00);
    acc(1'b1, HAC_OFS_CTL1, 8'h61);
    // Looked at before either side has left its off state
    check({6'h00, tx_clock_on, rx_clock_on}, 8'h03);
    idle(4);
    // Transparent: enable first, falling edge aligns, raw byte has 8 zeros
    acc(1'b1, HAC_OFS_CTL1, 8'h20);
    acc(1'b1, HAC_OFS_CTL1, 8'h22);
    acc(1'b1, HAC_OFS_CTL1, 8'h02);
    acc(1'b1, HAC_OFS_CTL1, 8'h22);
    acc(1'b1, HAC_OFS_FIFO, 8'h00);
    zeros(8'h08);
    acc(1'b1, HAC_OFS_CTL1, 8'h00);
    idle(40);
    // Filtered receive: all but the check bytes stored, first and last tagged
    acc(1'b1, HAC_OFS_CTL1, 8'hc0);
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, HAC_OFS_ADDR1, r1_tab[i]);
      acc(1'b1, HAC_OFS_ADDR2, r2_tab[i]);
      idle(1);
      peer.send_frame({16'h0000, 8'h5a, a2_tab[i], 8'h0c});
      idle(4);
      if (i > 0 && i < 4) begin
        rd(HAC_OFS_STATUS, 8'h11, 8'h33);
        rd(HAC_OFS_FIFO, 8'h0c);
        rd(HAC_OFS_FIFO, a2_tab[i]);
        idle(2);
        rd(HAC_OFS_STATUS, 8'h20, 8'h20);
        rd(HAC_OFS_FIFO, 8'h5a);
        idle(2);
      end
      rd(HAC_OFS_STATUS, 8'h00, 8'h03);
      idle(1);
    end
    end_of_test();
  end
endmodule
